// ==== rtl/acbd_decoder.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "acbd_map.svh"

// Notes on behaviour
// - one write-only 8-bit control register, loaded serially over select, data-in, clock
// - after select falls, the first one on data-in is the start bit
// - while idle, including after power-up, first one with select low starts a byte
// - during result readout, ones are ignored until result bit 6 has gone out
// - fastest operation is 16 serial clocks per conversion with overlapping bytes
// - byte layout: start 7, channel 6:4, range 3, mode 2, power 1:0
// - channel select picks which channels and common pin feed both converter inputs
// - range zero gives bipolar half-reference span, one gives unipolar full span
// - mode zero differential two's complement, one common-referenced straight binary
// - power field: 00 full down, 01 or 10 reduced, 11 normal
// - mode one: codes 0-3 even channels, 4-7 odd channels positive, negative common
// - mode zero: pairs 0/1..6/7, even positive, upper codes swap polarity
// - one bit sampled per rising clock edge while select low, MSB first
// - strobe high for one clock period, two periods after last byte bit
// - after strobe, 12 result bits go out on the next 12 rising edges
// - select high puts data output and strobe into high impedance
module acbd_decoder #(
  parameter int RES_W = 12
) (
  // system
  input  wire logic                 mclk,
  input  wire logic                 reset,
  // serial link; data and strobe on the link clock, enables follow select directly
  input  wire logic                 sclk,
  input  wire logic                 select_low,
  input  wire logic                 data_in,
  output logic                      data_out,
  output logic                      data_out_oe_n,
  output logic                      conversion_strobe,
  output logic                      conversion_strobe_oe_n,
  // converter core, on the link clock
  input  wire logic [RES_W-1:0]     conversion_result,
  // decoded settings, on mclk
  output logic [7:0]                positive_internal_input,
  output logic [8:0]                negative_internal_input,
  output logic [2:0]                channel_select,
  output logic                      range_unipolar,
  output logic                      mode_single_ended,
  output logic                      coding_binary,
  output logic [1:0]                power_setting,
  output acbd_pkg::acbd_power_e     power_mode,
  output logic                      settings_valid
);
  import acbd_pkg::*;

  // ---------------- link clock domain ----------------
  logic             lrst_s1;
  logic             lrst_s2;
  logic             receiving;
  logic [2:0]       rx_count;
  logic [6:0]       rx_shift;
  logic [3:0]       phase;
  logic [RES_W-1:0] result_hold;
  logic             byte_done;
  logic             hunt_ok;
  acbd_ctrl_t       conversion_control_byte;
  logic             load_toggle;

  // reset reaches the link side through two flops; sclk must run during it
  always_ff @(posedge sclk) begin
    lrst_s1 <= reset;
    lrst_s2 <= lrst_s1;
  end

  assign byte_done = receiving && (rx_count == `ACBD_RX_LAST);
  // readout past bit 6 lets a new start bit in, which gives the 16-clock cycle
  assign hunt_ok   = !receiving && (phase == `ACBD_PH_IDLE || phase >= `ACBD_PH_REARM);

  // select high clears at once, so a short deselect between edges still discards
  always_ff @(posedge sclk or posedge select_low) begin
    if (select_low) begin
      receiving <= 1'b0;
      rx_count  <= `ACBD_RX_FIRST;
      rx_shift  <= '0;
    end else if (lrst_s2) begin
      receiving <= 1'b0;
      rx_count  <= `ACBD_RX_FIRST;
      rx_shift  <= '0;
    end else if (hunt_ok) begin
      if (data_in) begin
        receiving <= 1'b1;
        rx_count  <= `ACBD_RX_FIRST;
        rx_shift  <= 7'h01;
      end
    end else if (receiving) begin
      rx_shift <= {rx_shift[5:0], data_in};
      rx_count <= rx_count + 3'h1;
      if (byte_done) begin
        receiving <= 1'b0;
      end
    end
  end

  // held control byte survives deselect; only a full byte replaces it
  always_ff @(posedge sclk) begin
    if (lrst_s2) begin
      conversion_control_byte <= `ACBD_RST_CTRL;
      load_toggle             <= 1'b0;
    end else if (byte_done && !select_low) begin
      conversion_control_byte <= {rx_shift, data_in};
      load_toggle             <= ~load_toggle;
    end
  end

  always_ff @(posedge sclk or posedge select_low) begin
    if (select_low) begin
      phase <= `ACBD_PH_IDLE;
    end else if (lrst_s2) begin
      phase <= `ACBD_PH_IDLE;
    end else if (byte_done) begin
      phase <= `ACBD_PH_LOADED;
    end else if (phase == `ACBD_PH_END) begin
      phase <= `ACBD_PH_IDLE;
    end else if (phase != `ACBD_PH_IDLE) begin
      phase <= phase + `ACBD_PH_STEP;
    end
  end

  always_ff @(posedge sclk or posedge select_low) begin
    if (select_low) begin
      conversion_strobe <= 1'b0;
      data_out          <= 1'b0;
      result_hold       <= '0;
    end else if (lrst_s2) begin
      conversion_strobe <= 1'b0;
      data_out          <= 1'b0;
      result_hold       <= '0;
    end else begin
      conversion_strobe <= (phase == `ACBD_PH_STROBE);
      if (phase == `ACBD_PH_STROBE) begin
        result_hold <= conversion_result;
      end
      if (phase >= `ACBD_PH_FIRST && phase <= `ACBD_PH_LAST) begin
        data_out <= result_hold[RES_W-1 - (32'(phase) - 32'(`ACBD_PH_FIRST))];
      end else begin
        data_out <= 1'b0;
      end
    end
  end

  // enables follow the pin directly: no clock edge is needed to let go
  assign data_out_oe_n          = select_low;
  assign conversion_strobe_oe_n = select_low;

  // ---------------- mclk domain ----------------
  logic       tog_s1;
  logic       tog_s2;
  logic       tog_s3;
  logic       take_byte;
  acbd_ctrl_t ctrl_seen;
  logic [2:0] sel;

  always_ff @(posedge mclk) begin
    if (reset) begin
      tog_s1 <= 1'b0;
      tog_s2 <= 1'b0;
      tog_s3 <= 1'b0;
    end else begin
      tog_s1 <= load_toggle;
      tog_s2 <= tog_s1;
      tog_s3 <= tog_s2;
    end
  end

  // word is stable for at least 8 sclk periods after the toggle (16 with select held low), far beyond the sync delay
  assign take_byte = tog_s2 ^ tog_s3;
  assign ctrl_seen = conversion_control_byte;
  assign sel       = ctrl_seen[`ACBD_SEL_HI:`ACBD_SEL_LO];

  always_ff @(posedge mclk) begin
    if (reset) begin
      channel_select    <= '0;
      range_unipolar    <= 1'b0;
      mode_single_ended <= 1'b0;
      coding_binary     <= 1'b0;
      power_setting     <= `ACBD_PD_NORMAL;
      settings_valid    <= 1'b0;
    end else if (take_byte) begin
      channel_select    <= sel;
      range_unipolar    <= ctrl_seen[`ACBD_RANGE_BIT];
      mode_single_ended <= ctrl_seen[`ACBD_MODE_BIT];
      coding_binary     <= ctrl_seen[`ACBD_MODE_BIT];
      power_setting     <= ctrl_seen[`ACBD_PD_HI:`ACBD_PD_LO];
      settings_valid    <= 1'b1;
    end
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      power_mode <= ACBD_PWR_NORMAL;
    end else if (take_byte) begin
      unique case (ctrl_seen[`ACBD_PD_HI:`ACBD_PD_LO])
        `ACBD_PD_FULL_DOWN: power_mode <= ACBD_PWR_DOWN;
        `ACBD_PD_NORMAL:    power_mode <= ACBD_PWR_NORMAL;
        default:            power_mode <= ACBD_PWR_REDUCED;
      endcase
    end
  end

  // positive index {sel[1:0],sel[2]}; differential negative is its pair partner
  always_ff @(posedge mclk) begin
    if (reset) begin
      positive_internal_input <= `ACBD_RST_POS;
      negative_internal_input <= `ACBD_RST_NEG;
    end else if (take_byte) begin
      positive_internal_input <= 8'h01 << {sel[1:0], sel[2]};
      if (ctrl_seen[`ACBD_MODE_BIT]) begin
        negative_internal_input <= 9'h001 << `ACBD_COMMON_IDX;
      end else begin
        negative_internal_input <= 9'h001 << {sel[1:0], ~sel[2]};
      end
    end
  end

  // ---------------- checks ----------------
  AST_STROBE_TIMING: assert property (
    @(posedge sclk) disable iff (select_low || lrst_s2)
    byte_done |=> !conversion_strobe ##1 !conversion_strobe ##1 conversion_strobe
                  ##1 !conversion_strobe)
    else $error("strobe not high exactly one period two clocks after last bit");

  AST_FIRST_BIT_AFTER_STROBE: assert property (
    @(posedge sclk) disable iff (select_low || lrst_s2 || byte_done)
    $fell(conversion_strobe) |-> data_out == result_hold[RES_W-1])
    else $error("result MSB not out on edge after strobe");

  AST_READOUT_LENGTH: assert property (
    @(posedge sclk) disable iff (select_low || lrst_s2)
    (phase == `ACBD_PH_FIRST) |-> ##11 (phase == `ACBD_PH_LAST) ##1 (phase == `ACBD_PH_END))
    else $error("readout did not span twelve edges");

  AST_NO_START_EARLY: assert property (
    @(posedge sclk) disable iff (select_low || lrst_s2)
    (phase >= `ACBD_PH_LOADED && phase < `ACBD_PH_REARM && !receiving) |=> !receiving)
    else $error("start bit taken before result bit 6");

  AST_START_ON_ONE: assert property (
    @(posedge sclk) disable iff (select_low || lrst_s2)
    (hunt_ok && data_in) |=> receiving && rx_count == `ACBD_RX_FIRST)
    else $error("first one did not open a byte");

  AST_BYTE_LENGTH: assert property (
    @(posedge sclk) disable iff (select_low || lrst_s2)
    $rose(receiving) |-> receiving [*7] ##1 !receiving)
    else $error("byte not eight bits long");

  AST_CTRL_CAPTURE: assert property (
    @(posedge sclk) disable iff (select_low || lrst_s2)
    byte_done |=> conversion_control_byte == {$past(rx_shift), $past(data_in)}
                  && conversion_control_byte[`ACBD_START_BIT])
    else $error("control byte not captured MSB first");

  AST_OE_FOLLOWS_SELECT: assert property (
    @(posedge mclk) disable iff (reset)
    data_out_oe_n == select_low && conversion_strobe_oe_n == select_low)
    else $error("output enables do not follow select");

  AST_SETTINGS_HOLD: assert property (
    @(posedge mclk) disable iff (reset)
    !take_byte |=> $stable(power_setting) && $stable(channel_select) && $stable(range_unipolar))
    else $error("settings changed without a new byte");

  AST_SINGLE_NEG_COMMON: assert property (
    @(posedge mclk) disable iff (reset)
    (take_byte && ctrl_seen[`ACBD_MODE_BIT])
      |=> negative_internal_input[`ACBD_COMMON_IDX] && $onehot(positive_internal_input))
    else $error("single-ended negative not on common pin");

  AST_DIFF_PAIR: assert property (
    @(posedge mclk) disable iff (reset)
    (take_byte && !ctrl_seen[`ACBD_MODE_BIT])
      |=> !negative_internal_input[`ACBD_COMMON_IDX]
          && ((positive_internal_input | negative_internal_input[7:0])
              == (8'h03 << {channel_select[1:0], 1'b0})))
    else $error("differential pair wrong");

  AST_POWER_DECODE: assert property (
    @(posedge mclk) disable iff (reset)
    settings_valid |-> (power_setting == `ACBD_PD_NORMAL) == (power_mode == ACBD_PWR_NORMAL)
                     && (power_setting == `ACBD_PD_FULL_DOWN) == (power_mode == ACBD_PWR_DOWN))
    else $error("power mode decode wrong");

endmodule : acbd_decoder

`default_nettype wire

// ==== rtl/acbd_map.svh ====
`ifndef ACBD_MAP_SVH
`define ACBD_MAP_SVH

// control byte field positions
`define ACBD_START_BIT   7
`define ACBD_SEL_HI      6
`define ACBD_SEL_LO      4
`define ACBD_RANGE_BIT   3
`define ACBD_MODE_BIT    2
`define ACBD_PD_HI       1
`define ACBD_PD_LO       0

// power field codes
`define ACBD_PD_FULL_DOWN 2'h0
`define ACBD_PD_NORMAL    2'h3

// receive bit counter: value after the start bit and at the last data bit of a byte
`define ACBD_RX_FIRST    3'h0
`define ACBD_RX_LAST     3'h6

// conversion phase counter, counted in serial clock edges after the last byte bit
`define ACBD_PH_IDLE     4'h0
`define ACBD_PH_LOADED   4'h1
`define ACBD_PH_STROBE   4'h2
`define ACBD_PH_FIRST    4'h3
`define ACBD_PH_LAST     4'hE
`define ACBD_PH_END      4'hF
`define ACBD_PH_REARM    4'h9
`define ACBD_PH_STEP     4'h1

// reset values of the held settings, and the common pin index
`define ACBD_RST_CTRL    8'h03
`define ACBD_RST_POS     8'h01
`define ACBD_RST_NEG     9'h002
`define ACBD_COMMON_IDX  8

`endif

// ==== rtl/acbd_pkg.sv ====
package acbd_pkg;

  typedef enum logic [1:0] {
    ACBD_PWR_DOWN,
    ACBD_PWR_REDUCED,
    ACBD_PWR_NORMAL
  } acbd_power_e;

  typedef logic [7:0] acbd_ctrl_t;

endpackage : acbd_pkg

// ==== testbench/acbd_host_model.sv ====
`timescale 1ns/1ps
`default_nettype none
module acbd_host_model (
  // serial link
  output logic      sclk,
  output logic      select_low,
  output logic      data_in,
  // device answers
  input  wire logic data_out,
  input  wire logic conversion_strobe
);
  logic hist_strb [64];
  logic hist_dout [64];

  initial begin
    sclk       = 1'b0;
    select_low = 1'b1;
    data_in    = 1'b0;
  end

  // link-side reset only moves on sclk edges; select stays high so nothing is taken
  task automatic idle_clocks(input int n);
    for (int i = 0; i < n; i++) begin
      #62.5 sclk = 1'b1;
      #62.5 sclk = 1'b0;
    end
  endtask : idle_clocks

  // clock stands still between frames; samples taken just after each rise
  task automatic run(input logic [63:0] pat, input int n);
    #13 select_low = 1'b0;
    for (int i = 0; i < n; i++) begin
      data_in = pat[n-1-i];
      #62.5 sclk = 1'b1;
      #1 hist_strb[i] = conversion_strobe;
      hist_dout[i] = data_out;
      #61.5 sclk = 1'b0;
    end
    #20 select_low = 1'b1;
    // released line must not keep its last value
    data_in = ~data_in;
  endtask : run
endmodule : acbd_host_model
`default_nettype wire

// ==== testbench/adc_control_byte_decoder_bench.sv ====
`timescale 1ns/1ps
`default_nettype none
module adc_control_byte_decoder_bench;
  import acbd_pkg::*;
  logic        mclk;
  logic        reset;
  wire logic   sclk;
  wire logic   select_low;
  wire logic   data_in;
  logic        data_out;
  logic        data_out_oe_n;
  logic        conversion_strobe;
  logic        conversion_strobe_oe_n;
  logic [11:0] conversion_result;
  logic [7:0]  positive_internal_input;
  logic [8:0]  negative_internal_input;
  logic [2:0]  channel_select;
  logic        range_unipolar;
  logic        mode_single_ended;
  logic        coding_binary;
  logic [1:0]  power_setting;
  acbd_power_e power_mode;
  logic        settings_valid;
  int          miscompares;
  int          num_checks;
  int          cycles;
  logic [7:0]  b;
  logic [11:0] res;

  acbd_decoder uut (.mclk(mclk), .reset(reset), .sclk(sclk), .select_low(select_low),
    .data_in(data_in), .data_out(data_out), .data_out_oe_n(data_out_oe_n),
    .conversion_strobe(conversion_strobe), .conversion_strobe_oe_n(conversion_strobe_oe_n),
    .conversion_result(conversion_result), .positive_internal_input(positive_internal_input),
    .negative_internal_input(negative_internal_input), .channel_select(channel_select),
    .range_unipolar(range_unipolar), .mode_single_ended(mode_single_ended),
    .coding_binary(coding_binary), .power_setting(power_setting), .power_mode(power_mode),
    .settings_valid(settings_valid));

  acbd_host_model host (.sclk(sclk), .select_low(select_low), .data_in(data_in),
    .data_out(data_out), .conversion_strobe(conversion_strobe));

  initial begin
    mclk = 1'b0;
    forever #25 mclk = ~mclk;
  end

  task automatic check(input string what, input logic [8:0] exp, input logic [8:0] got);
    num_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask : check

  task automatic end_of_test();
    $display("checks %0d mismatches %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : end_of_test

  // expected routing worked out from the channel tables
  task automatic check_settings(input logic [7:0] v, input logic ok);
    logic [2:0]  p;
    acbd_power_e pm;
    p  = {v[5:4], v[6]};
    pm = (v[1:0] == 2'h0) ? ACBD_PWR_DOWN : (v[1:0] == 2'h3) ? ACBD_PWR_NORMAL : ACBD_PWR_REDUCED;
    check("pos", 9'h001 << p, {1'b0, positive_internal_input});
    check("neg", v[2] ? 9'h100 : 9'h001 << (p ^ 3'h1), negative_internal_input);
    check("sel", 9'(v[6:4]), 9'(channel_select));
    check("range", 9'(v[3]), 9'(range_unipolar));
    check("mode", 9'(v[2]), 9'(mode_single_ended));
    check("coding", 9'(v[2]), 9'(coding_binary));
    check("power", 9'(v[1:0]), 9'(power_setting));
    check("power_mode", 9'(pm), 9'(power_mode));
    check("valid", 9'(ok), 9'(settings_valid));
  endtask : check_settings

  task automatic check_frame(input int k, input logic [11:0] r);
    check("strobe_early", 9'h0, 9'(host.hist_strb[k+8]));
    check("strobe", 9'h1, 9'(host.hist_strb[k+9]));
    check("strobe_late", 9'h0, 9'(host.hist_strb[k+10]));
    for (int j = 0; j < 12; j++) begin
      check("result_bit", 9'(r[11-j]), 9'(host.hist_dout[k+10+j]));
    end
  endtask : check_frame

  task automatic frame(input logic [63:0] pat, input int n, input logic [11:0] r);
    @(posedge mclk);
    conversion_result <= r;
    fork
      host.run(pat, n);
      begin
        #150 check("oe_on", 9'h0, 9'({data_out_oe_n, conversion_strobe_oe_n}));
      end
    join
    #1 check("oe_off", 9'h3, 9'({data_out_oe_n, conversion_strobe_oe_n}));
    repeat (8) @(posedge mclk);
  endtask : frame

  always @(posedge mclk) begin
    cycles <= cycles + 1;
    if (cycles == 6000) begin
      miscompares++;
      end_of_test();
    end
  end

  initial begin
    reset             = 1'b1;
    conversion_result = 12'h000;
    miscompares       = 0;
    num_checks        = 0;
    cycles            = 0;
    b                 = 8'h03;
    // the link side has no reset of its own: clock it during and after reset
    fork
      host.idle_clocks(3);
      repeat (8) @(posedge mclk);
    join
    reset <= 1'b0;
    host.idle_clocks(3);
    repeat (4) @(posedge mclk);
    check_settings(8'h03, 1'b0);
    $display("test reset_values done");
    // every code, mode, range and power value; zero to two leading zeros before the start bit
    for (int i = 0; i < 16; i++) begin
      b   = {1'b1, 3'(i), i[0], i[3], i[1:0]};
      res = 12'h5A3 ^ 12'(i * 273);
      frame(64'(b) << 23, i % 3 + 31, res);
      check_frame(i % 3, res);
      check_settings(b, 1'b1);
    end
    $display("test decode_table done");
    // deselect in mid-byte: nothing may change
    frame(64'hB, 4, 12'hFFF);
    check_settings(b, 1'b1);
    $display("test abort done");
    // select held low: sixteen zeros, byte, ones during readout, byte at clock 16
    res = 12'h9C6;
    frame({2'h0, 16'h0000, 8'hC6, 8'hFF, 8'hB1, 22'h0}, 62, res);
    check_frame(16, res);
    check_frame(32, res);
    check_settings(8'hB1, 1'b1);
    $display("test back_to_back done");
    end_of_test();
  end
endmodule : adc_control_byte_decoder_bench
`default_nettype wire
